// ==== internal_clock_spread_and_monitor.sv ====
// System tick generator with spread modulation and a two-chain clock watch
`timescale 1ns/100ps
`default_nettype none
module internal_clock_spread_and_monitor (
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // Oscillator pins
    input  wire logic        main_osc,
    input  wire logic        aux_osc,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rd_data,
    // Tick and reset request
    output logic             sys_tick,
    output logic             spread_active,
    output logic             int_reset_req
);

    // Percentage clamped into the legal range
    function automatic logic [2:0] clamp_pct(input logic [2:0] pct);
        logic [2:0] r;
        r = pct;
        if (pct < clkwatch_pkg::PCT_MIN) begin
            r = clkwatch_pkg::PCT_MIN;
        end else if (pct > clkwatch_pkg::PCT_MAX) begin
            r = clkwatch_pkg::PCT_MAX;
        end
        return r;
    endfunction

    // Increment change per triangle step for a spread percentage
    function automatic logic [5:0] spread_step(input logic [2:0] pct);
        int full;
        full = int'(clkwatch_pkg::NCO_INC) * int'(clamp_pct(pct));
        return 6'(full / (100 * clkwatch_pkg::HALF_MOD));
    endfunction

    // True when the two periods differ by more than the limit
    function automatic logic too_far(input logic [15:0] a,
                                     input logic [15:0] b);
        logic [15:0] big;
        logic [15:0] diff;
        big  = (a > b) ? a : b;
        diff = (a > b) ? (a - b) : (b - a);
        return (23'(diff) * 23'd100) >
               (23'(big) * 23'(clkwatch_pkg::MISM_PCT));
    endfunction

    // Oscillator pins, two stages, then an edge stage
    logic [1:0] osc_meta;
    logic [1:0] osc_sync;
    logic [1:0] osc_last;

    // Configuration
    logic                               spread_en;
    logic [2:0]                         spread_pct;

    // Flags and self-check
    logic [clkwatch_pkg::FLAG_W-1:0]    flags;
    logic [clkwatch_pkg::FLAG_W-1:0]    raw_fault;
    logic [clkwatch_pkg::FLAG_W-1:0]    next_flags;
    clkwatch_pkg::check_state_type      check_state;
    clkwatch_pkg::check_state_type      next_check_state;
    logic [11:0]                        check_timer;
    logic                               check_pass;
    logic                               check_fail;

    // Tick generator
    logic [clkwatch_pkg::ACC_W-1:0]     phase;
    logic signed [6:0]                  tri_pos;
    logic                               tri_up;

    // Read path
    logic [31:0]                        read_word;

    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_meta <= 2'h0;
            osc_sync <= 2'h0;
            osc_last <= 2'h0;
        end else if (ce) begin
            osc_meta <= {aux_osc, main_osc};
            osc_sync <= osc_meta;
            osc_last <= osc_sync;
        end
    end

    wire logic [1:0] osc_rise = osc_sync & ~osc_last;

    watch_if main_link ();
    watch_if aux_link ();

    wire logic forcing = check_state == clkwatch_pkg::CHECK_FORCE;

    assign main_link.target_edge = osc_rise[0];
    assign main_link.ref_edge    = osc_rise[1];
    assign main_link.force_stall = forcing;
    assign aux_link.target_edge  = osc_rise[1];
    assign aux_link.ref_edge     = osc_rise[0];
    assign aux_link.force_stall  = forcing;

    watch_chain main_chain (
        .clock  (clock),
        .arst_n (arst_n),
        .ce     (ce),
        .link   (main_link.chain)
    );

    watch_chain aux_chain (
        .clock  (clock),
        .arst_n (arst_n),
        .ce     (ce),
        .link   (aux_link.chain)
    );

    // Register decode
    wire logic hit_cfg   = addr == clkwatch_pkg::CFG_OFFSET;
    wire logic hit_flags = addr == clkwatch_pkg::FLAGS_OFFSET;
    wire logic hit_check = addr == clkwatch_pkg::CHECK_OFFSET;
    wire logic hit_per   = addr == clkwatch_pkg::PERIOD_OFFSET;
    wire logic cfg_wr    = wr_en && hit_cfg;
    wire logic flags_wr  = wr_en && hit_flags;
    wire logic check_go  = cfg_wr && wr_data[clkwatch_pkg::CHECK_GO_BIT];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            spread_en  <= clkwatch_pkg::SPREAD_RESET;
            spread_pct <= clkwatch_pkg::PCT_RESET;
        end else if (ce && cfg_wr) begin
            spread_en  <= wr_data[clkwatch_pkg::SPREAD_EN_BIT];
            spread_pct <= clamp_pct(wr_data[clkwatch_pkg::PCT_LSB +: clkwatch_pkg::PCT_W]);
        end
    end

    wire logic both_valid = main_link.period_valid && aux_link.period_valid;
    wire logic mismatch   = both_valid && too_far(main_link.period,
                                                  aux_link.period);

    assign raw_fault[clkwatch_pkg::RST_FLAG_BIT]  = main_link.stall;
    assign raw_fault[clkwatch_pkg::MAIN_FLAG_BIT] = main_link.stall;
    assign raw_fault[clkwatch_pkg::AUX_FLAG_BIT]  = aux_link.stall;
    assign raw_fault[clkwatch_pkg::MISM_FLAG_BIT] = mismatch;

    // Faults during a self-check are staged, not real
    wire logic suppress = check_state != clkwatch_pkg::CHECK_IDLE;
    wire logic [clkwatch_pkg::FLAG_W-1:0] flag_set =
        suppress ? 4'h0 : raw_fault;

    // clear only once the fault is gone
    wire logic [clkwatch_pkg::FLAG_W-1:0] flag_clr =
        flags_wr ? (wr_data[clkwatch_pkg::FLAG_W-1:0] & ~raw_fault) : 4'h0;

    // Set wins over a clear in the same cycle
    assign next_flags = (flags & ~flag_clr) | flag_set;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 4'h0;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    wire logic both_stalled = main_link.stall && aux_link.stall;
    wire logic any_stalled  = main_link.stall || aux_link.stall;
    wire logic timed_out    = check_timer == clkwatch_pkg::CHECK_LIMIT;

    always_comb begin
        next_check_state = check_state;
        case (check_state)
            clkwatch_pkg::CHECK_IDLE: begin
                if (check_go) begin
                    next_check_state = clkwatch_pkg::CHECK_FORCE;
                end
            end
            clkwatch_pkg::CHECK_FORCE: begin
                if (both_stalled || timed_out) begin
                    next_check_state = clkwatch_pkg::CHECK_DRAIN;
                end
            end
            clkwatch_pkg::CHECK_DRAIN: begin
                if (!any_stalled || timed_out) begin
                    next_check_state = clkwatch_pkg::CHECK_IDLE;
                end
            end
            default: begin
                next_check_state = clkwatch_pkg::CHECK_IDLE;
            end
        endcase
    end

    wire logic state_moves = next_check_state != check_state;

    // Timer restarts on each state change
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            check_state <= clkwatch_pkg::CHECK_IDLE;
            check_timer <= 12'h000;
        end else if (ce) begin
            check_state <= next_check_state;
            if (state_moves || !suppress) begin
                check_timer <= 12'h000;
            end else if (!timed_out) begin
                check_timer <= check_timer + 12'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            check_pass <= 1'b0;
            check_fail <= 1'b0;
        end else if (ce) begin
            if (check_go && !suppress) begin
                check_pass <= 1'b0;
                check_fail <= 1'b0;
            end else if (forcing && both_stalled) begin
                check_pass <= 1'b1;
            end else if (forcing && timed_out) begin
                check_fail <= 1'b1;
            end
        end
    end

    wire logic [5:0] step = spread_step(spread_pct);
    wire logic signed [13:0] offset = $signed({1'b0, step}) * tri_pos;

    // triangle sweep, one period per modulation cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tri_pos <= 7'sh00;
            tri_up  <= 1'b1;
        end else if (ce) begin
            if (!spread_en) begin
                tri_pos <= 7'sh00;
                tri_up  <= 1'b1;
            end else if (tri_up) begin
                tri_up  <= tri_pos != $signed(clkwatch_pkg::TRI_PEAK - 7'h01);
                tri_pos <= tri_pos + 7'sh01;
            end else begin
                tri_up  <= tri_pos == $signed(7'h01 - clkwatch_pkg::TRI_PEAK);
                tri_pos <= tri_pos - 7'sh01;
            end
        end
    end

    // nominal increment gives 20 MHz from 25 MHz
    wire logic [16:0] inc = spread_en ?
        17'($signed({1'b0, clkwatch_pkg::NCO_INC}) + offset) :
        clkwatch_pkg::NCO_INC;
    wire logic [16:0] phase_sum = {1'b0, phase} + inc;

    // tick carries the spread as jitter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase    <= 16'h0000;
            sys_tick <= 1'b0;
        end else if (ce) begin
            phase    <= phase_sum[15:0];
            sys_tick <= phase_sum[16];
        end
    end

    // Status outputs, registered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            spread_active <= 1'b0;
            int_reset_req <= 1'b0;
        end else if (ce) begin
            spread_active <= spread_en;
            int_reset_req <= next_flags[clkwatch_pkg::RST_FLAG_BIT];
        end
    end

    // Read words
    wire logic [31:0] cfg_word =
        (32'(spread_en) << clkwatch_pkg::SPREAD_EN_BIT) |
        (32'(spread_pct) << clkwatch_pkg::PCT_LSB);
    wire logic [31:0] check_word =
        (32'(suppress) << clkwatch_pkg::CHECK_BUSY_BIT) |
        (32'(check_pass) << clkwatch_pkg::CHECK_PASS_BIT) |
        (32'(check_fail) << clkwatch_pkg::CHECK_FAIL_BIT);

    // Unmapped offsets read as zero
    assign read_word = hit_cfg   ? cfg_word :
                       hit_flags ? 32'(flags) :
                       hit_check ? check_word :
                       hit_per   ? {aux_link.period, main_link.period} :
                       32'h0000_0000;

    wire logic osc_alive = !(main_link.quiet && aux_link.quiet);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 32'h0000_0000;
        end else if (ce && rd_en && osc_alive) begin
            rd_data <= read_word;
        end
    end

endmodule
`default_nettype wire

// ==== clkwatch_pkg.sv ====
// Constants shared by the clock spread and clock watch block
package clkwatch_pkg;

    // Register byte offsets
    localparam logic [7:0] CFG_OFFSET    = 8'h00;
    localparam logic [7:0] FLAGS_OFFSET  = 8'h04;
    localparam logic [7:0] CHECK_OFFSET  = 8'h08;
    localparam logic [7:0] PERIOD_OFFSET = 8'h0C;

    // general_config_one fields
    localparam int         SPREAD_EN_BIT = 0;
    localparam int         PCT_LSB       = 1;
    localparam int         PCT_W         = 3;
    localparam int         CHECK_GO_BIT  = 4;
    localparam logic       SPREAD_RESET  = 1'b0;
    localparam logic [2:0] PCT_RESET     = 3'h3;
    localparam logic [2:0] PCT_MIN       = 3'h1;
    localparam logic [2:0] PCT_MAX       = 3'h5;

    // Flag register bits, write one to clear
    localparam int FLAG_W        = 4;
    localparam int RST_FLAG_BIT  = 0;
    localparam int MAIN_FLAG_BIT = 1;
    localparam int AUX_FLAG_BIT  = 2;
    localparam int MISM_FLAG_BIT = 3;

    // Self-check status bits
    localparam int CHECK_BUSY_BIT = 0;
    localparam int CHECK_PASS_BIT = 1;
    localparam int CHECK_FAIL_BIT = 2;

    // Clock rates and modulation
    localparam int CLOCK_KHZ  = 25000;
    localparam int SYS_KHZ    = 20000;
    localparam int SSM_MOD_HZ = 156250;
    localparam int MOD_CYCLES = CLOCK_KHZ * 1000 / SSM_MOD_HZ;
    localparam int HALF_MOD   = MOD_CYCLES / 2;
    localparam int ACC_W      = 16;
    localparam logic [16:0] NCO_INC  = 17'((SYS_KHZ * 65536) / CLOCK_KHZ);
    localparam logic [6:0]  TRI_PEAK = 7'(HALF_MOD / 2);

    // Clock watch timing
    localparam int STALL_US    = 50;
    localparam int OSC_NOM_KHZ = 1000;
    localparam int PERIOD_W    = 16;
    localparam int MISM_PCT    = 30;
    localparam logic [7:0]  STALL_EDGES  = 8'((STALL_US * OSC_NOM_KHZ + 999) / 1000);
    localparam logic [15:0] QUIET_CYCLES = 16'(STALL_US * CLOCK_KHZ / 1000);
    localparam logic [11:0] CHECK_LIMIT  = 12'(2 * STALL_US * CLOCK_KHZ / 1000);

    // Self-check sequencer
    typedef enum logic [1:0] {
        CHECK_IDLE  = 2'b00,
        CHECK_FORCE = 2'b01,
        CHECK_DRAIN = 2'b10
    } check_state_type;

endpackage

// ==== watch_if.sv ====
// Carrier between the top and one clock watch chain
`timescale 1ns/100ps
`default_nettype none
interface watch_if;
    logic                              target_edge;
    logic                              ref_edge;
    logic                              force_stall;
    logic                              stall;
    logic                              quiet;
    logic                              period_valid;
    logic [clkwatch_pkg::PERIOD_W-1:0] period;

    modport chain (
        input  target_edge,
        input  ref_edge,
        input  force_stall,
        output stall,
        output quiet,
        output period_valid,
        output period
    );
    modport owner (
        output target_edge,
        output ref_edge,
        output force_stall,
        input  stall,
        input  quiet,
        input  period_valid,
        input  period
    );
endinterface
`default_nettype wire

// ==== watch_chain.sv ====
// One clock watch chain: times a target oscillator against a reference
`timescale 1ns/100ps
`default_nettype none
module watch_chain (
    // Clock, reset and enable
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic ce,
    // Edges in, verdicts out
    watch_if.chain    link
);
    logic [7:0]                        ref_count;
    logic [clkwatch_pkg::PERIOD_W-1:0] sys_count;
    logic [clkwatch_pkg::PERIOD_W-1:0] period;
    logic                              period_valid;

    // A forced stall hides the target edges
    wire logic edge_seen = link.target_edge && !link.force_stall;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ref_count <= 8'h00;
        end else if (ce) begin
            if (edge_seen) begin
                ref_count <= 8'h00;
            end else if (link.ref_edge && ref_count != 8'hff) begin
                ref_count <= ref_count + 8'h01;
            end
        end
    end

    // Own-clock period on real edges; a self-check leaves no stale period behind
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sys_count    <= 16'h0001;
            period       <= 16'h0000;
            period_valid <= 1'b0;
        end else if (ce) begin
            if (link.target_edge) begin
                sys_count    <= 16'h0001;
                period       <= sys_count;
                period_valid <= 1'b1;
            end else if (sys_count != 16'hffff) begin
                sys_count <= sys_count + 16'h0001;
            end
        end
    end

    assign link.stall        = ref_count >= clkwatch_pkg::STALL_EDGES;
    assign link.quiet        = sys_count >= clkwatch_pkg::QUIET_CYCLES;
    assign link.period       = period;
    assign link.period_valid = period_valid;
endmodule
`default_nettype wire

// ==== internal_clock_spread_and_monitor_assertions.sv ====
// Port-level checks for the clock spread and clock watch block
`timescale 1ns/100ps
`default_nettype none
module internal_clock_spread_and_monitor_assertions (
    // Clock, reset and enable
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        ce,
    // Oscillator pins
    input wire logic        main_osc,
    input wire logic        aux_osc,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    // Tick and reset request
    input wire logic        sys_tick,
    input wire logic        spread_active,
    input wire logic        int_reset_req
);
    logic        main_prev;
    logic        aux_prev;
    logic [11:0] main_quiet;
    logic [6:0]  aux_rises;

    // Decodes of pin edges and register strobes
    wire main_rise = main_osc && !main_prev;
    wire aux_rise  = aux_osc && !aux_prev;
    wire cfg_wr    = wr_en && ce && addr == clkwatch_pkg::CFG_OFFSET;
    wire cfg_rd    = rd_en && ce && addr == clkwatch_pkg::CFG_OFFSET;
    wire flag_clr  = wr_en && ce && addr == clkwatch_pkg::FLAGS_OFFSET && wr_data[0];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Main quiet time and reference rises since the last main rise; saturate
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            main_prev  <= 1'b0;
            aux_prev   <= 1'b0;
            main_quiet <= 12'h000;
            aux_rises  <= 7'h00;
        end else begin
            main_prev  <= main_osc;
            aux_prev   <= aux_osc;
            main_quiet <= main_rise ? 12'h000 : main_quiet + 12'(main_quiet != 12'hfff);
            aux_rises  <= main_rise ? 7'h00 : aux_rises + 7'(aux_rise && aux_rises != 7'h7f);
        end
    end

    AST_SPREAD_FOLLOWS: assert property (cfg_wr ##1 ce
        |=> spread_active == $past(wr_data[clkwatch_pkg::SPREAD_EN_BIT], 2))
        else $error("spread output ignores written enable");
    AST_SPREAD_CAUSE: assert property ($changed(spread_active) |-> $past(cfg_wr, 2))
        else $error("spread output changed without a write");
    AST_TICK_GAP: assert property ((!sys_tick && ce && $past(arst_n, 3)) |=> sys_tick)
        else $error("tick missing two cycles running");
    AST_RDATA_HOLD: assert property ($changed(rd_data) |-> $past(rd_en && ce))
        else $error("read data changed without a read");
    AST_CFG_READ: assert property (cfg_rd |=> rd_data[0] == spread_active
        && rd_data[clkwatch_pkg::CHECK_GO_BIT] == 1'b0)
        else $error("config readback wrong");
    AST_PCT_RANGE: assert property (cfg_rd |=>
        rd_data[clkwatch_pkg::PCT_LSB +: clkwatch_pkg::PCT_W] inside {[3'h1:3'h5]})
        else $error("spread percent out of range");
    AST_RST_CAUSE: assert property ($rose(int_reset_req) |-> aux_rises >= 7'd50)
        else $error("reset request without main stall");
    AST_RST_STICKY: assert property ($fell(int_reset_req) |-> $past(flag_clr))
        else $error("reset request dropped without clear");
    AST_CLEAR_REFUSED: assert property ((flag_clr && int_reset_req && main_quiet >= 12'd1300)
        |=> int_reset_req)
        else $error("reset request cleared while main stalled");
endmodule

bind internal_clock_spread_and_monitor internal_clock_spread_and_monitor_assertions watch_checks (
    .clock(clock), .arst_n(arst_n), .ce(ce), .main_osc(main_osc), .aux_osc(aux_osc),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sys_tick(sys_tick), .spread_active(spread_active), .int_reset_req(int_reset_req)
);
`default_nettype wire

// ==== internal_clock_spread_and_monitor_test.sv ====
// Self-checking bench for the clock spread and clock watch block
`timescale 1ns/100ps
`default_nettype none
module internal_clock_spread_and_monitor_test;
    logic        clock    = 1'b0;
    logic        arst_n   = 1'b0;
    logic        ce       = 1'b1;
    logic        main_osc = 1'b0;
    logic        aux_osc  = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wr_data  = 32'h0000_0000;
    logic        wr_en    = 1'b0;
    logic        rd_en    = 1'b0;
    logic [31:0] rd_data;
    logic        sys_tick;
    logic        spread_active;
    logic        int_reset_req;
    logic        main_run = 1'b1;
    logic        aux_run  = 1'b1;
    logic [31:0] got;
    int          main_per = 25;
    int          aux_per  = 25;
    int          main_cnt = 0;
    int          aux_cnt  = 0;
    int          cycles   = 0;
    int          mismatches  = 0;
    int          check_count = 0;

    internal_clock_spread_and_monitor dut (
        .clock(clock), .arst_n(arst_n), .ce(ce), .main_osc(main_osc), .aux_osc(aux_osc),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sys_tick(sys_tick), .spread_active(spread_active), .int_reset_req(int_reset_req)
    );

    // 25 MHz clock
    always #20 clock = ~clock;

    // Oscillators at 1 MHz; a stopped one holds its level like a dead oscillator
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (main_run) begin
            main_cnt <= (main_cnt + 1) % main_per;
            main_osc <= main_cnt < main_per / 2;
        end
        if (aux_run) begin
            aux_cnt <= (aux_cnt + 1) % aux_per;
            aux_osc <= aux_cnt < aux_per / 2;
        end
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic check_in(input int g, input int lo, input int hi);
        check_count++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h..%h", $time, g, lo, hi);
        end
    endtask

    // Bus cycles; the strobe drops at the taking edge
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 got = rd_data;
    endtask

    task automatic settle_and_clear(input int n);
        repeat (n) @(posedge clock);
        reg_write(clkwatch_pkg::FLAGS_OFFSET, 32'h0000_000f);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got, 32'h0000_0000);
    endtask

    task automatic count_ticks(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock);
            #1 c += int'(sys_tick === 1'b1);
        end
    endtask

    task automatic test_config;
        reg_read(clkwatch_pkg::CFG_OFFSET);
        check_eq(got, 32'h0000_0006);
        reg_read(8'h10);
        check_eq(got, 32'h0000_0000);
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_000e);
        reg_read(clkwatch_pkg::CFG_OFFSET);
        check_eq(got, 32'h0000_000a);
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0000);
        reg_read(clkwatch_pkg::CFG_OFFSET);
        check_eq(got, 32'h0000_0002);
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0007);
        reg_read(clkwatch_pkg::CFG_OFFSET);
        check_eq({got[31:1], spread_active}, 32'h0000_0007);
        // Frozen by ce: a write must not land
        @(posedge clock);
        ce <= 1'b0;
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0006);
        @(posedge clock);
        ce <= 1'b1;
        reg_read(clkwatch_pkg::CFG_OFFSET);
        check_eq(got, 32'h0000_0007);
    endtask

    task automatic test_tick;
        int n;
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0006);
        count_ticks(500, n);
        check_in(n, 380, 420);
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_000b);
        count_ticks(480, n);
        check_in(n, 364, 404);
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0006);
        reg_read(clkwatch_pkg::PERIOD_OFFSET);
        check_eq(got, 32'h0019_0019);
    endtask

    task automatic stall_case(input logic stop_main, input logic [31:0] exp);
        main_run <= !stop_main;
        aux_run  <= stop_main;
        repeat (1400) @(posedge clock);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got & 32'h0000_0007, exp);
        check_eq({31'h0, int_reset_req}, {31'h0, exp[0]});
        reg_write(clkwatch_pkg::FLAGS_OFFSET, 32'h0000_000f);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got & 32'h0000_0007, exp);
        main_run <= 1'b1;
        aux_run  <= 1'b1;
        settle_and_clear(150);
        check_eq({31'h0, int_reset_req}, 32'h0000_0000);
    endtask

    task automatic mismatch_case(input int per, input logic [31:0] exp);
        aux_per <= per;
        repeat (200) @(posedge clock);
        // Clear is refused while the mismatch stands
        reg_write(clkwatch_pkg::FLAGS_OFFSET, 32'h0000_000f);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got, exp);
        repeat (200) @(posedge clock);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got & 32'h0000_0008, exp);
        aux_per <= 25;
        settle_and_clear(200);
    endtask

    task automatic test_self_check;
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0016);
        reg_read(clkwatch_pkg::CHECK_OFFSET);
        check_eq(got & 32'h0000_0001, 32'h0000_0001);
        for (int i = 0; i < 100 && got[0] !== 1'b0; i++) begin
            repeat (40) @(posedge clock);
            reg_read(clkwatch_pkg::CHECK_OFFSET);
        end
        check_eq(got, 32'h0000_0002);
        reg_read(clkwatch_pkg::FLAGS_OFFSET);
        check_eq(got, 32'h0000_0000);
    endtask

    // No oscillator: a read is refused and the last answer stays
    task automatic test_no_osc;
        reg_read(clkwatch_pkg::CHECK_OFFSET);
        main_run <= 1'b0;
        aux_run  <= 1'b0;
        repeat (1400) @(posedge clock);
        reg_read(clkwatch_pkg::PERIOD_OFFSET);
        check_eq(got, 32'h0000_0002);
        // Self-check with both oscillators dead must time out and fail
        reg_write(clkwatch_pkg::CFG_OFFSET, 32'h0000_0016);
        repeat (2600) @(posedge clock);
        main_run <= 1'b1;
        aux_run  <= 1'b1;
        settle_and_clear(200);
        reg_read(clkwatch_pkg::CHECK_OFFSET);
        check_eq(got, 32'h0000_0004);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        test_config();
        test_tick();
        stall_case(1'b1, 32'h0000_0003);
        stall_case(1'b0, 32'h0000_0004);
        mismatch_case(35, 32'h0000_0000);
        mismatch_case(37, 32'h0000_0008);
        test_self_check();
        test_no_osc();
        results();
    end
endmodule
`default_nettype wire
